/* design/ecc_flow_through_datapath.sv */
`timescale 1ns/1ps
// Functional notes
// - Writes only generate checkbits, no checking
// - Direct write path captures while latch enable low
// - Output latch holds data and checkbits; bus enables
// - Write queue pushes on system clock, full blocks
// - Write queue pops on memory clock, empty blocks
// - Memory input latch; syndrome is regenerated XOR incoming
// - Normal mode corrects; output latch; byte-wise drive
// - Byte mux steered by lanes or queued lanes
// - Read queue active-low push and pop, flags block
// - Shared clock adds one cycle at boundaries
// - First push after reset is ignored
// - Pointers advance; filling write overwrites output
// - Partial write merges bytes, then checkbits
// - Injected checkbits mismatch raises both error flags
// - Load enable captures low sixteen data bits
// - Low three bits select operating mode
// - Depth bit selects eight or sixteen entries
// - Writing clear bit one clears diagnostics
// - Readback bit drives configuration onto data bus
// - Detect mode leaves read data uncorrected
// - Error-data mode outputs captured error word
module ecc_flow_through_datapath import ecc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [DW-1:0] SYS_DATA_IN,
  output logic [DW-1:0] SYS_DATA_OUT,
  output logic [NB-1:0] SYS_DATA_OE_N,
  output logic [NB-1:0] PARITY_OUT,
  input wire logic SYS_OUT_EN_N,
  input wire logic [NB-1:0] BYTE_LANE_SEL,
  input wire logic WR_PATH_FIFO_SEL,
  input wire logic SYS_IN_LATCH_EN_N,
  input wire logic SYS_OUT_LATCH_EN,
  input wire logic [DW-1:0] MEM_DATA_IN,
  output logic [DW-1:0] MEM_DATA_OUT,
  output logic MEM_DATA_OE_N,
  input wire logic MEM_OUT_EN_N,
  input wire logic [CW-1:0] CHECKBIT_IN_BUS,
  input wire logic CHECKBIT_OUT_SEL,
  output logic [CW-1:0] CHECKBIT_SYNDROME_BUS,
  output logic CHECKBIT_SYNDROME_OE_N,
  input wire logic WR_FIFO_PUSH_EN,
  input wire logic WR_FIFO_POP_EN,
  output logic WR_FIFO_FULL,
  output logic WR_FIFO_EMPTY,
  input wire logic MEM_READY,
  input wire logic MEM_IN_LATCH_EN,
  input wire logic MEM_OUT_LATCH_EN,
  input wire logic RD_PATH_FIFO_SEL,
  input wire logic RD_FIFO_PUSH_EN_N,
  input wire logic RD_FIFO_POP_EN_N,
  output logic RD_FIFO_FULL,
  output logic RD_FIFO_EMPTY,
  input wire logic CFG_LOAD_EN,
  output logic ERROR_FLAG_N,
  output logic MULTI_ERROR_FLAG_N
);
  localparam int WFW = DW + NB;

  // ==========================================================
  // Pin sample and state
  typedef struct packed {
    logic [DW-1:0] sd;
    logic [NB-1:0] be;
    logic soe_n;
    logic wr_path_fifo_sel;
    logic sys_in_latch_en_n_n;
    logic sys_out_latch_en;
    logic [DW-1:0] md;
    logic moe_n;
    logic [CW-1:0] checkbit_in_bus;
    logic checkbit_out_sel;
    logic wr_fifo_push_en;
    logic wr_fifo_pop_en;
    logic mem_ready;
    logic mem_in_latch_en;
    logic mem_out_latch_en;
    logic rd_path_fifo_sel;
    logic rd_fifo_push_en_n_n;
    logic rd_fifo_pop_en_n_n;
    logic cfg_load_en;
  } pins_t;

  typedef struct packed {
    pins_t s1;
    pins_t s2;
    logic [15:0] cfg;
    logic [DW-1:0] sys_in;
    logic [DW-1:0] out_data;
    logic [CW-1:0] out_cb;
    logic [DW-1:0] md;
    logic [CW-1:0] checkbit_in_bus;
    logic md_fresh;
    logic [DW-1:0] mdout;
    logic [DW-1:0] err_data;
    logic [CW-1:0] diag_cb;
    logic [CW-1:0] syn1;
    logic [CW-1:0] syn_all;
    logic [3:0] err_cnt;
    logic [1:0] etype;
    logic logged;
    logic pend;
    logic [DW-1:0] sdo;
    logic [NB-1:0] sd_oe_n;
    logic [NB-1:0] par;
    logic [DW-1:0] mdo;
    logic md_oe_n;
    logic [CW-1:0] cbs;
    logic cbs_oe_n;
    logic err_n;
    logic multi_error_flag_n_n;
  } st_t;

  st_t st;
  st_t next_st;
  pins_t pins;
  op_mode_t mode;
  logic [DW-1:0] wr_word;
  logic [NB-1:0] wr_be;
  logic [CW-1:0] syn;
  logic err;
  logic multi;
  logic [DW-1:0] corr;
  logic [DW-1:0] path_b;
  logic [DW-1:0] merged;
  logic [CW-1:0] gen;
  logic [LIM_W-1:0] lim;
  logic clear;
  logic evt;
  logic [DW-1:0] rd_word;
  logic [DW-1:0] diag;
  logic [DW-1:0] sd_next;

  fifo_if #(.W(WFW), .LW(LIM_W)) wf();
  fifo_if #(.W(DW), .LW(LIM_W)) rf();
  stream_if #(.W(WFW)) wb_in();
  stream_if #(.W(WFW)) wb_out();

  word_fifo #(.W(WFW), .D(16)) u_wr_fifo
  (
    .clk(CLOCK),
    .rst(RST),
    .f(wf)
  );

  word_fifo #(.W(DW), .D(16)) u_rd_fifo
  (
    .clk(CLOCK),
    .rst(RST),
    .f(rf)
  );

  two_slot_buf #(.W(WFW)) u_wr_buf
  (
    .clk(CLOCK),
    .rst(RST),
    .up(wb_in),
    .dn(wb_out)
  );

  assign pins = '{sd: SYS_DATA_IN, be: BYTE_LANE_SEL,
    soe_n: SYS_OUT_EN_N, wr_path_fifo_sel: WR_PATH_FIFO_SEL,
    sys_in_latch_en_n_n: SYS_IN_LATCH_EN_N, sys_out_latch_en: SYS_OUT_LATCH_EN,
    md: MEM_DATA_IN, moe_n: MEM_OUT_EN_N, checkbit_in_bus: CHECKBIT_IN_BUS,
    checkbit_out_sel: CHECKBIT_OUT_SEL, wr_fifo_push_en: WR_FIFO_PUSH_EN,
    wr_fifo_pop_en: WR_FIFO_POP_EN, mem_ready: MEM_READY,
    mem_in_latch_en: MEM_IN_LATCH_EN, mem_out_latch_en: MEM_OUT_LATCH_EN,
    rd_path_fifo_sel: RD_PATH_FIFO_SEL, rd_fifo_push_en_n_n: RD_FIFO_PUSH_EN_N,
    rd_fifo_pop_en_n_n: RD_FIFO_POP_EN_N, cfg_load_en: CFG_LOAD_EN};

  // ==========================================================
  // Queues: both see the same depth setting
  assign lim = st.cfg[DEPTH_BIT] ? DEPTH_SINGLE : DEPTH_DUAL;
  assign wf.limit = lim;
  assign rf.limit = lim;
  assign wf.push = st.s2.wr_path_fifo_sel && st.s2.wr_fifo_push_en;
  assign wf.din = {st.s2.be, st.s2.sd};
  // A pop still in flight must find room in the buffer
  assign wf.pop = st.s2.wr_fifo_pop_en && wb_in.ready
    && (!st.pend || st.s2.mem_ready);
  assign wb_in.valid = st.pend;
  assign wb_in.data = wf.dout;
  assign wb_out.ready = st.s2.mem_ready;
  assign rf.push = st.s2.rd_path_fifo_sel && !st.s2.rd_fifo_push_en_n_n;
  assign rf.din = corr;
  assign rf.pop = st.s2.rd_path_fifo_sel && !st.s2.rd_fifo_pop_en_n_n;

  // ==========================================================
  // Datapath
  always_comb
  begin
    mode = op_mode_t'(st.cfg[MODE_HI:MODE_LO]);
    wr_word = st.s2.wr_path_fifo_sel ? wb_out.data[DW-1:0] : st.sys_in;
    wr_be = st.s2.wr_path_fifo_sel ? wb_out.data[WFW-1:DW] : st.s2.be;
    syn = check_gen(st.md) ^ st.checkbit_in_bus;
    // Top bit becomes parity over all 72 bits read, so a flipped
    // checkbit reads as single and a flipped data bit corrects in normal mode
    syn[7] = ^syn;
    err = |syn;
    // Injection flags any mismatch as both error kinds
    multi = (mode == MODE_INJECT) ? err : err && !syn[7];
    corr = (mode == MODE_NORMAL) ? correct_word(st.md, syn)
      : st.md;
    path_b = (mode == MODE_ERR_DATA) ? st.err_data : corr;
    for (int i = 0; i < NB; i++)
      merged[8*i +: 8] = wr_be[i] ? path_b[8*i +: 8]
        : wr_word[8*i +: 8];
    gen = check_gen(merged);
    rd_word = st.s2.rd_path_fifo_sel ? rf.dout : st.mdout;
    diag = {26'h0000000, st.syn_all, st.etype, st.err_cnt,
      st.syn1, st.diag_cb, st.checkbit_in_bus};
    if (st.cfg[RB_BIT])
      sd_next = {48'h000000000000, st.cfg};
    else if (mode == MODE_ERR_DATA)
      sd_next = st.err_data;
    else if (mode == MODE_DIAG)
      sd_next = diag;
    else
      sd_next = rd_word;
    clear = st.s2.cfg_load_en && st.s2.sd[CLEAR_BIT];
    evt = st.md_fresh && err;
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    next_st = st;
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.pend = wf.pop && !wf.empty;
    if (!st.s2.sys_in_latch_en_n_n)
      next_st.sys_in = st.s2.sd;
    if (!st.s2.sys_out_latch_en)
    begin
      next_st.out_data = merged;
      next_st.out_cb = gen;
    end
    next_st.md_fresh = !st.s2.mem_in_latch_en;
    if (!st.s2.mem_in_latch_en)
    begin
      next_st.md = st.s2.md;
      next_st.checkbit_in_bus = (mode == MODE_INJECT) ? wr_word[CW-1:0]
        : st.s2.checkbit_in_bus;
    end
    if (!st.s2.mem_out_latch_en)
      next_st.mdout = corr;
    if (st.s2.cfg_load_en)
      next_st.cfg = st.s2.sd[15:0];
    // Clear first, then a same-cycle error still logs
    if (clear)
    begin
      next_st.err_data = '0;
      next_st.diag_cb = '0;
      next_st.syn1 = '0;
      next_st.syn_all = '0;
      next_st.err_cnt = '0;
      next_st.etype = '0;
      next_st.logged = 1'b0;
    end
    if (evt)
    begin
      next_st.syn_all = syn;
      if (next_st.err_cnt != ERR_CNT_MAX)
        next_st.err_cnt = next_st.err_cnt + 1'b1;
      if (!next_st.logged)
      begin
        next_st.err_data = st.md;
        next_st.diag_cb = st.checkbit_in_bus;
        next_st.syn1 = syn;
        next_st.etype = {multi, 1'b1};
        next_st.logged = 1'b1;
      end
    end
    next_st.sdo = sd_next;
    for (int i = 0; i < NB; i++)
    begin
      next_st.par[i] = (^sd_next[8*i +: 8]) ^ st.cfg[PSEL_BIT];
      next_st.sd_oe_n[i] = !(!st.s2.soe_n && st.s2.be[i]);
    end
    next_st.mdo = st.out_data;
    next_st.md_oe_n = st.s2.moe_n;
    next_st.cbs_oe_n = !(st.s2.checkbit_out_sel || !st.s2.moe_n);
    next_st.cbs = st.s2.moe_n ? syn : st.out_cb;
    next_st.err_n = !err;
    next_st.multi_error_flag_n_n = !multi;
    if (RST)
    begin
      next_st = '0;
      next_st.cfg = CFG_RESET;
      next_st.sd_oe_n = '1;
      next_st.md_oe_n = 1'b1;
      next_st.cbs_oe_n = 1'b1;
      next_st.err_n = 1'b1;
      next_st.multi_error_flag_n_n = 1'b1;
      next_st.s1.sys_in_latch_en_n_n = 1'b1;
      next_st.s2.sys_in_latch_en_n_n = 1'b1;
      next_st.s1.soe_n = 1'b1;
      next_st.s2.soe_n = 1'b1;
      next_st.s1.moe_n = 1'b1;
      next_st.s2.moe_n = 1'b1;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    st <= next_st;
  end

  // ==========================================================
  // Outputs
  assign SYS_DATA_OUT = st.sdo;
  assign SYS_DATA_OE_N = st.sd_oe_n;
  assign PARITY_OUT = st.par;
  assign MEM_DATA_OUT = st.mdo;
  assign MEM_DATA_OE_N = st.md_oe_n;
  assign CHECKBIT_SYNDROME_BUS = st.cbs;
  assign CHECKBIT_SYNDROME_OE_N = st.cbs_oe_n;
  assign WR_FIFO_FULL = wf.full;
  assign WR_FIFO_EMPTY = wf.empty;
  assign RD_FIFO_FULL = rf.full;
  assign RD_FIFO_EMPTY = rf.empty;
  assign ERROR_FLAG_N = st.err_n;
  assign MULTI_ERROR_FLAG_N = st.multi_error_flag_n_n;
endmodule : ecc_flow_through_datapath

/* design/ecc_pkg.sv */
package ecc_pkg;
  // ==========================================================
  // Widths and field positions
  localparam int DW = 64;
  localparam int CW = 8;
  localparam int NB = 8;
  localparam int LIM_W = 5;
  localparam int MODE_LO = 0;
  localparam int MODE_HI = 2;
  localparam int CLEAR_BIT = 3;
  localparam int DEPTH_BIT = 4;
  localparam int PSEL_BIT = 5;
  localparam int RB_BIT = 6;
  localparam logic [15:0] CFG_RESET = 16'h0003;
  localparam logic [LIM_W-1:0] DEPTH_DUAL = 5'h08;
  localparam logic [LIM_W-1:0] DEPTH_SINGLE = 5'h10;
  localparam logic [3:0] ERR_CNT_MAX = 4'hF;

  typedef enum logic [2:0] {
    MODE_ERR_DATA = 3'h0,
    MODE_DIAG = 3'h1,
    MODE_GEN_DET = 3'h2,
    MODE_NORMAL = 3'h3,
    MODE_INJECT = 3'h4
  } op_mode_t;

  // ==========================================================
  // Code: Hamming positions skipping powers of two, plus an
  // overall parity bit so double errors are told from singles
  function automatic logic [6:0] hpos(input int j);
    int k;
    logic [6:0] r;
    k = 0;
    r = 7'h00;
    for (int p = 3; p < 72; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (k == j)
          r = 7'(p);
        k++;
      end
    end
    return r;
  endfunction : hpos

  function automatic logic [CW-1:0] check_gen(input logic [DW-1:0] d);
    logic [CW-1:0] c;
    c = 8'h00;
    for (int j = 0; j < DW; j++)
      if (d[j])
        c[6:0] = c[6:0] ^ hpos(j);
    c[7] = (^d) ^ (^c[6:0]);
    return c;
  endfunction : check_gen

  function automatic logic [DW-1:0] correct_word(
    input logic [DW-1:0] d,
    input logic [CW-1:0] s
  );
    logic [DW-1:0] r;
    r = d;
    for (int j = 0; j < DW; j++)
      if (s[7] && s[6:0] == hpos(j))
        r[j] = ~d[j];
    return r;
  endfunction : correct_word
endpackage : ecc_pkg

/* design/ecc_ifs.sv */
`timescale 1ns/1ps
// ==========================================================
// Queue access
interface fifo_if #(parameter int W = 72, parameter int LW = 5);
  logic push;
  logic pop;
  logic full;
  logic empty;
  logic [W-1:0] din;
  logic [W-1:0] dout;
  logic [LW-1:0] limit;
  modport owner(input push, pop, din, limit, output full, empty, dout);
  modport user(output push, pop, din, limit, input full, empty, dout);
endinterface : fifo_if

// ==========================================================
// Valid/ready stream
interface stream_if #(parameter int W = 72);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, data, input ready);
  modport snk(input valid, data, output ready);
endinterface : stream_if

/* design/word_fifo.sv */
`timescale 1ns/1ps
module word_fifo import ecc_pkg::*;
#(
  parameter int W = 72,
  parameter int D = 16
)
(
  input wire logic clk,
  input wire logic rst,
  fifo_if.owner f
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic primed;
    logic full;
    logic empty;
    logic [W-1:0] dout;
  } fst_t;

  fst_t st;
  fst_t next_st;
  logic [W-1:0] mem [D];
  logic do_push;
  logic do_pop;
  logic store;

  function automatic logic [AW-1:0] step(
    input logic [AW-1:0] p,
    input logic [AW:0] lim
  );
    if ({1'b0, p} == lim - 1'b1)
      return '0;
    return p + 1'b1;
  endfunction : step

  // ==========================================================
  // Next state
  always_comb
  begin
    next_st = st;
    do_push = f.push && !st.full;
    do_pop = f.pop && !st.empty;
    // First push after reset only primes the write side
    store = do_push && st.primed;
    if (do_push && !st.primed)
      next_st.primed = 1'b1;
    if (store)
      next_st.wp = step(st.wp, f.limit);
    if (do_pop)
    begin
      next_st.rp = step(st.rp, f.limit);
      next_st.dout = mem[st.rp];
    end
    if (store && !do_pop)
      next_st.cnt = st.cnt + 1'b1;
    else if (!store && do_pop)
      next_st.cnt = st.cnt - 1'b1;
    // Filling write lands on the last read slot
    if (store && next_st.cnt == f.limit)
      next_st.dout = f.din;
    // One cycle extra at the boundaries: both sides share one clock
    next_st.empty = next_st.cnt == 0 || (store && st.cnt == 0);
    next_st.full = next_st.cnt >= f.limit
      || (do_pop && st.cnt >= f.limit);
    if (rst)
    begin
      next_st = '0;
      next_st.empty = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    st <= next_st;
    if (store)
      mem[st.wp] <= f.din;
  end

  assign f.full = st.full;
  assign f.empty = st.empty;
  assign f.dout = st.dout;
endmodule : word_fifo

/* design/two_slot_buf.sv */
`timescale 1ns/1ps
module two_slot_buf
#(
  parameter int W = 72
)
(
  input wire logic clk,
  input wire logic rst,
  stream_if.snk up,
  stream_if.src dn
);
  typedef struct packed {
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic [1:0] cnt;
  } bst_t;

  bst_t st;
  bst_t next_st;
  logic take;
  logic give;

  // ==========================================================
  // Two slots so a stall downstream drops nothing in flight
  always_comb
  begin
    next_st = st;
    take = up.valid && st.cnt != 2'h2;
    give = st.cnt != 2'h0 && dn.ready;
    if (give)
    begin
      next_st.d0 = st.d1;
      next_st.cnt = st.cnt - 1'b1;
    end
    if (take)
    begin
      if (next_st.cnt == 2'h0)
        next_st.d0 = up.data;
      else
        next_st.d1 = up.data;
      next_st.cnt = next_st.cnt + 1'b1;
    end
    if (rst)
      next_st = '0;
  end

  always_ff @(posedge clk)
  begin
    st <= next_st;
  end

  assign up.ready = st.cnt != 2'h2;
  assign dn.valid = st.cnt != 2'h0;
  assign dn.data = st.d0;
endmodule : two_slot_buf

/* bench/ecc_chk_sva.sv */
`timescale 1ns/1ps
// ==========================================================
// Port checks
module ecc_chk import ecc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [DW-1:0] SYS_DATA_OUT,
  input wire logic [NB-1:0] SYS_DATA_OE_N,
  input wire logic [NB-1:0] PARITY_OUT,
  input wire logic SYS_OUT_EN_N,
  input wire logic MEM_OUT_EN_N,
  input wire logic MEM_DATA_OE_N,
  input wire logic CHECKBIT_OUT_SEL,
  input wire logic CHECKBIT_SYNDROME_OE_N,
  input wire logic WR_FIFO_PUSH_EN,
  input wire logic WR_FIFO_POP_EN,
  input wire logic WR_FIFO_FULL,
  input wire logic WR_FIFO_EMPTY,
  input wire logic RD_FIFO_PUSH_EN_N,
  input wire logic RD_FIFO_EMPTY,
  input wire logic ERROR_FLAG_N,
  input wire logic MULTI_ERROR_FLAG_N
);
  default clocking dc @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  // Pin histories: inputs pass sync stages, so flags trail pins
  logic [7:0] wpu;
  logic [7:0] wpo;
  logic [7:0] rpu;
  logic [NB-1:0] bpar;
  logic cb_on;
  assign cb_on = CHECKBIT_OUT_SEL || !MEM_OUT_EN_N;
  always_comb
    for (int i = 0; i < NB; i++)
      bpar[i] = (^SYS_DATA_OUT[8*i +: 8]) ^ PARITY_OUT[i];
  always_ff @(posedge CLOCK)
    if (RST)
    begin
      wpu <= 8'h00;
      wpo <= 8'h00;
      rpu <= 8'h00;
    end
    else
    begin
      wpu <= {wpu[6:0], WR_FIFO_PUSH_EN};
      wpo <= {wpo[6:0], WR_FIFO_POP_EN};
      rpu <= {rpu[6:0], !RD_FIFO_PUSH_EN_N};
    end
  a_checkbit_syndrome_bus_enable:
    assert property ($stable(cb_on)[*6] |-> CHECKBIT_SYNDROME_OE_N == !cb_on)
      else $error("checkbit bus enable wrong");
  a_mem_drive:
    assert property ($stable(MEM_OUT_EN_N)[*6]
      |-> MEM_DATA_OE_N == MEM_OUT_EN_N) else $error("memory enable wrong");
  a_sys_quiet:
    assert property (SYS_OUT_EN_N[*6] |-> SYS_DATA_OE_N == 8'hFF)
      else $error("system bus driven while off");
  a_parity_byte:
    assert property (bpar == 8'h00 || bpar == 8'hFF)
      else $error("byte parity inconsistent");
  a_multi_err:
    assert property (!MULTI_ERROR_FLAG_N |-> !ERROR_FLAG_N)
      else $error("multiple error without error");
  a_wr_fill:
    assert property ($fell(WR_FIFO_EMPTY) |-> wpu != 8'h00)
      else $error("write queue filled without push");
  a_wr_full:
    assert property ($rose(WR_FIFO_FULL) |-> wpu != 8'h00)
      else $error("write queue full without push");
  a_wr_drain:
    assert property ($rose(WR_FIFO_EMPTY) |-> wpo != 8'h00)
      else $error("write queue emptied without pop");
  a_rd_fill:
    assert property ($fell(RD_FIFO_EMPTY) |-> rpu != 8'h00)
      else $error("read queue filled without push");
  c_full: cover property ($rose(WR_FIFO_FULL));
  c_rd: cover property ($fell(RD_FIFO_EMPTY));
  c_multi: cover property ($fell(MULTI_ERROR_FLAG_N));
endmodule : ecc_chk

bind ecc_flow_through_datapath ecc_chk chk_u (.CLOCK(CLOCK), .RST(RST),
  .SYS_DATA_OUT(SYS_DATA_OUT), .SYS_DATA_OE_N(SYS_DATA_OE_N),
  .PARITY_OUT(PARITY_OUT), .SYS_OUT_EN_N(SYS_OUT_EN_N),
  .MEM_OUT_EN_N(MEM_OUT_EN_N), .MEM_DATA_OE_N(MEM_DATA_OE_N),
  .CHECKBIT_OUT_SEL(CHECKBIT_OUT_SEL),
  .CHECKBIT_SYNDROME_OE_N(CHECKBIT_SYNDROME_OE_N),
  .WR_FIFO_PUSH_EN(WR_FIFO_PUSH_EN), .WR_FIFO_POP_EN(WR_FIFO_POP_EN),
  .WR_FIFO_FULL(WR_FIFO_FULL), .WR_FIFO_EMPTY(WR_FIFO_EMPTY),
  .RD_FIFO_PUSH_EN_N(RD_FIFO_PUSH_EN_N), .RD_FIFO_EMPTY(RD_FIFO_EMPTY),
  .ERROR_FLAG_N(ERROR_FLAG_N), .MULTI_ERROR_FLAG_N(MULTI_ERROR_FLAG_N));

/* bench/mem_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Memory array on the far side
module mem_model import ecc_pkg::*;
(
  input wire logic clk,
  input wire logic [DW-1:0] wdata,
  input wire logic [CW-1:0] wcb,
  input wire logic wr_n,
  input wire logic [DW-1:0] flip,
  input wire logic stall,
  output logic [DW-1:0] rdata,
  output logic [CW-1:0] rcb,
  output logic ready
);
  // All-zero word with zero checkbits is a valid codeword
  logic [DW-1:0] word = '0;
  logic [CW-1:0] cb = 8'h00;
  initial
  begin
    rdata = '0;
    rcb = 8'h00;
  end
  assign ready = !stall;
  always @(posedge clk)
    if (!wr_n)
    begin
      word <= wdata;
      cb <= wcb;
      // Released bus: garbage, so a stale value never looks right
      rdata <= ~rdata;
      rcb <= ~rcb;
    end
    else
    begin
      rdata <= word ^ flip;
      rcb <= cb;
    end
endmodule : mem_model

/* bench/tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, DW'(e), DW'(g))
// ==========================================================
// Bench top
module tb_top import ecc_pkg::*; ();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [DW-1:0] sdi = '0;
  logic [DW-1:0] flip = '0;
  logic [NB-1:0] lanes = 8'hFF;
  logic soe_n = 1'b1, wsel = 1'b0, sile_n = 1'b0, sole = 1'b0;
  logic moe_n = 1'b1, checkbit_out_sel = 1'b0, wpush = 1'b0, wpop = 1'b0;
  logic mile = 1'b1, mole = 1'b0, rsel = 1'b0, rpush_n = 1'b1;
  logic rpop_n = 1'b1, cfg_ld = 1'b0, stall = 1'b0;
  logic [DW-1:0] sdo, mdi, mdo, d, f1, s;
  logic [NB-1:0] sdo_oe_n, par, l;
  logic [CW-1:0] checkbit_in_bus, cbs;
  logic mdo_oe_n, cbs_oe_n, wfull, wempty, rfull, rempty;
  logic err_n, multi_error_flag_n_n, mrdy;
  logic [15:0] v;
  logic [DW-1:0] wq[$];
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 32'h1B5A;

  always #5 clk = ~clk;

  ecc_flow_through_datapath dut_u (.CLOCK(clk), .RST(rst),
    .SYS_DATA_IN(sdi), .SYS_DATA_OUT(sdo), .SYS_DATA_OE_N(sdo_oe_n),
    .PARITY_OUT(par), .SYS_OUT_EN_N(soe_n), .BYTE_LANE_SEL(lanes),
    .WR_PATH_FIFO_SEL(wsel), .SYS_IN_LATCH_EN_N(sile_n),
    .SYS_OUT_LATCH_EN(sole), .MEM_DATA_IN(mdi), .MEM_DATA_OUT(mdo),
    .MEM_DATA_OE_N(mdo_oe_n), .MEM_OUT_EN_N(moe_n),
    .CHECKBIT_IN_BUS(checkbit_in_bus), .CHECKBIT_OUT_SEL(checkbit_out_sel),
    .CHECKBIT_SYNDROME_BUS(cbs), .CHECKBIT_SYNDROME_OE_N(cbs_oe_n),
    .WR_FIFO_PUSH_EN(wpush), .WR_FIFO_POP_EN(wpop), .WR_FIFO_FULL(wfull),
    .WR_FIFO_EMPTY(wempty), .MEM_READY(mrdy), .MEM_IN_LATCH_EN(mile),
    .MEM_OUT_LATCH_EN(mole), .RD_PATH_FIFO_SEL(rsel),
    .RD_FIFO_PUSH_EN_N(rpush_n), .RD_FIFO_POP_EN_N(rpop_n),
    .RD_FIFO_FULL(rfull), .RD_FIFO_EMPTY(rempty), .CFG_LOAD_EN(cfg_ld),
    .ERROR_FLAG_N(err_n), .MULTI_ERROR_FLAG_N(multi_error_flag_n_n));

  mem_model mem_u (.clk(clk), .wdata(mdo), .wcb(cbs), .wr_n(mdo_oe_n),
    .flip(flip), .stall(stall), .rdata(mdi), .rcb(checkbit_in_bus), .ready(mrdy));

  // ==========================================================
  // Shared tasks
  task automatic check(input string n, input logic [DW-1:0] e,
    input logic [DW-1:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask : ticks

  task automatic cfg(input logic [15:0] c);
    sdi = {48'h0, c};
    cfg_ld = 1'b1;
    ticks(1);
    cfg_ld = 1'b0;
    ticks(6);
  endtask : cfg

  // Memory is released before capture starts, so no garbage is logged
  task automatic rd(input logic [DW-1:0] f);
    flip = f;
    moe_n = 1'b1;
    checkbit_out_sel = 1'b1;
    ticks(5);
    mile = 1'b0;
    mole = 1'b0;
    soe_n = 1'b0;
    lanes = 8'hFF;
    ticks(8);
  endtask : rd

  task automatic wr(input logic [DW-1:0] w, input logic [NB-1:0] b);
    soe_n = 1'b1;
    mile = 1'b1;
    sdi = w;
    lanes = b;
    wsel = 1'b0;
    sole = 1'b0;
    moe_n = 1'b0;
    checkbit_out_sel = 1'b0;
    ticks(8);
  endtask : wr

  // Kind: 0 write push, 1 write pop, 2 read push, 3 read pop
  task automatic fifo_op(input int kind, input int n);
    for (int i = 0; i < n; i++)
    begin
      sdi = {$random(seed), $random(seed)};
      if (kind == 0)
        wq.push_back(sdi);
      wpush = (kind == 0);
      wpop = (kind == 1);
      rpush_n = (kind != 2);
      rpop_n = (kind != 3);
      ticks(1);
    end
    wpush = 1'b0;
    wpop = 1'b0;
    rpush_n = 1'b1;
    rpop_n = 1'b1;
    ticks(8);
  endtask : fifo_op

  function automatic logic [DW-1:0] mrg(input logic [DW-1:0] sv,
    input logic [DW-1:0] mv, input logic [NB-1:0] lv);
    for (int i = 0; i < NB; i++)
      mrg[8*i +: 8] = lv[i] ? mv[8*i +: 8] : sv[8*i +: 8];
  endfunction : mrg

  function automatic logic [NB-1:0] pty(input logic [DW-1:0] w,
    input logic odd);
    for (int i = 0; i < NB; i++)
      pty[i] = (^w[8*i +: 8]) ^ odd;
  endfunction : pty

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Scenarios
  initial
  begin
    ticks(3);
    rst = 1'b0;
    ticks(1);
    `CHK("sys_oe", 8'hFF, sdo_oe_n);
    `CHK("queues", 4'h5, {wfull, wempty, rfull, rempty});
    for (int k = 0; k < 5; k++)
    begin
      v = 16'h0040 | 16'(k) | (16'(k % 2) << 5);
      cfg(v);
      `CHK("readback", v, sdo[15:0]);
      `CHK("parity", pty({48'h0, v}, v[5]), par);
    end
    d = {$random(seed), $random(seed)};
    f1 = 64'h1 << 6'($random(seed));
    cfg(16'h000B);
    cfg(16'h0003);
    wr(d, 8'h00);
    `CHK("mem_word", d, mdo);
    `CHK("mem_oe", 2'b00, {mdo_oe_n, cbs_oe_n});
    sole = 1'b1;
    sdi = ~d;
    ticks(8);
    `CHK("held_word", d, mdo);
    rd('0);
    `CHK("clean", d, sdo);
    `CHK("clean_flags", 2'b11, {multi_error_flag_n_n, err_n});
    `CHK("clean_syn", 8'h00, cbs);
    `CHK("sd_drive", 8'h00, sdo_oe_n);
    rd(f1);
    `CHK("fixed", d, sdo);
    `CHK("single", 2'b10, {multi_error_flag_n_n, err_n});
    rd(f1 | {f1[0], f1[DW-1:1]});
    `CHK("double", 2'b00, {multi_error_flag_n_n, err_n});
    cfg(16'h0002);
    rd(f1);
    `CHK("detect_only", d ^ f1, sdo);
    flip = '0;
    cfg(16'h0000);
    `CHK("err_word", d ^ f1, sdo);
    cfg(16'h0001);
    `CHK("err_type", 2'b01, sdo[29:28]);
    cfg(16'h0009);
    cfg(16'h0001);
    `CHK("diag_clr", 6'h00, sdo[29:24]);
    cfg(16'h0000);
    `CHK("err_clr", 64'h0, sdo);
    cfg(16'h0003);
    rd('0);
    s = {$random(seed), $random(seed)};
    l = 8'($random(seed));
    wr(s, l);
    `CHK("merge", mrg(s, d, l), mdo);
    rd('0);
    `CHK("merge_rd", mrg(s, d, l), sdo);
    `CHK("merge_ok", 1'b1, err_n);
    cfg(16'h0004);
    sdi = {56'h0, mem_u.cb ^ 8'h01};
    rd('0);
    `CHK("inject", 2'b00, {multi_error_flag_n_n, err_n});
    sdi[7:0] = mem_u.cb;
    ticks(8);
    `CHK("inject_ok", 2'b11, {multi_error_flag_n_n, err_n});
    cfg(16'h0003);
    wsel = 1'b1;
    lanes = 8'h00;
    fifo_op(0, 1);
    `CHK("dummy", 1'b1, wempty);
    fifo_op(0, 8);
    `CHK("w_full", 2'b10, {wfull, wempty});
    stall = 1'b1;
    fifo_op(1, 8);
    `CHK("w_stall", 2'b00, {wfull, wempty});
    `CHK("w_head", wq[1], mdo);
    stall = 1'b0;
    fifo_op(1, 8);
    `CHK("w_drain", 2'b01, {wfull, wempty});
    wsel = 1'b0;
    cfg(16'h0013);
    rsel = 1'b1;
    fifo_op(2, 17);
    `CHK("r_full", 2'b10, {rfull, rempty});
    // Output is read only after a pop: the filling push overwrites it
    fifo_op(3, 1);
    `CHK("r_word", mrg(s, d, l), sdo);
    `CHK("r_room", 1'b0, rfull);
    fifo_op(3, 15);
    `CHK("r_empty", 1'b1, rempty);
    tally_and_finish();
  end
endmodule : tb_top
